/* hdl/mbs_pkg.sv */
`default_nettype none

package mbs_pkg;

   // bus geometry
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int N_CPU = 2;

   // register byte offsets, one aligned word each
   localparam logic [ADDR_W-1:0] OFS_MBOX_VALUE = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_MBOX_SET_MASK = 6'h04;
   localparam logic [ADDR_W-1:0] OFS_MBOX_BIT_CLEAR_MASK = 6'h08;
   localparam logic [ADDR_W-1:0] OFS_LOCK_IRQ_CONFIG = 6'h0C;
   localparam logic [ADDR_W-1:0] OFS_LOCK_ZERO_TAKE = 6'h10;
   localparam logic [ADDR_W-1:0] OFS_LOCK_ONE_TAKE = 6'h14;
   localparam logic [ADDR_W-1:0] OFS_LOCK_ZERO_HOLDER = 6'h18;
   localparam logic [ADDR_W-1:0] OFS_LOCK_ONE_HOLDER = 6'h1C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MANUAL_TRIGGER = 6'h20;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 6'h24;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h28;

   // field positions
   localparam int CFG_POLARITY_BIT = 0;
   localparam int CFG_ROUTE_LSB = 1;
   localparam int TAKE_BIT = 0;
   localparam int HOLDER_BUSY_BIT = 8;

   // reset values
   localparam logic [DATA_W-1:0] MBOX_RST = 32'h0000_0000;
   localparam logic LOCK_POLARITY_RST = 1'h0;
   localparam logic [1:0] ROUTE_RST = 2'h0;
   localparam logic [1:0] FORCE_RST = 2'h0;
   localparam logic [1:0] STATUS_RST = 2'h0;
   localparam logic [1:0] MASK_RST = 2'h0;

   // one Avalon-MM request as the master drives it
   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
   } mbs_av_req_t;

   // answer to one Avalon-MM master
   typedef struct packed {
      logic waitrequest;
      logic [DATA_W-1:0] readdata;
   } mbs_av_rsp_t;

endpackage

`default_nettype wire

/* hdl/mbs_lock.sv */
`default_nettype none

module mbs_lock #(
   parameter int OW = 2
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic take_req,
   input wire logic free_req,
   input wire logic [OW-1:0] who,
   output logic busy,
   output logic [OW-1:0] holder
);

   typedef struct packed {
      logic busy;
      logic [OW-1:0] holder;
   } mbs_lock_st_t;

   mbs_lock_st_t st_r;
   mbs_lock_st_t st_nxt;

   // release from anyone; a take only succeeds while free
   always_comb begin
      st_nxt = st_r;
      if (free_req) begin
         st_nxt.busy = 1'b0; // R9 R10
         st_nxt.holder = '0;
      end else if (take_req && !st_r.busy) begin
         st_nxt.busy = 1'b1; // R6
         st_nxt.holder = who;
      end
   end

   // free and ownerless out of reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0; // R18
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busy = st_r.busy;
   assign holder = st_r.holder;

endmodule

`default_nettype wire

/* hdl/mbs_top.sv */
// The placing of the registers and the Avalon-MM slave port were decided locally.
`default_nettype none

// Notes on behaviour
// (R1) one 32-bit mailbox shared by all CPUs
// (R2) plain read/write of whole mailbox value
// (R3) clear-mask write clears selected mailbox bits
// (R4) set-mask write sets selected mailbox bits
// (R5) two independent locks on the register bus
// (R6) read of free lock returns 1, records owner
// (R7) read of held lock returns 0, no change
// (R8) held lock reads 0 until released
// (R9) writing 1 to take register frees lock
// (R10) any CPU may release any lock
// (R11) holder register shows state and owner
// (R12) soft interrupt event on take or free
// (R13) config bit selects lock interrupt polarity
// (R14) lock zero feeds irq zero, one feeds one
// (R15) manual trigger register forces soft interrupts
// (R16) each soft irq routed to cpu or external
// (R17) simultaneous takes serialised, one winner only
// (R18) reset: locks free, no owner, mailbox zero
module mbs_top #(
   parameter int N_CPU = mbs_pkg::N_CPU
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire mbs_pkg::mbs_av_req_t [N_CPU-1:0] av_req,
   output mbs_pkg::mbs_av_rsp_t [N_CPU-1:0] av_rsp,
   output logic irq,
   output logic [1:0] soft_irq_cpu,
   output logic [1:0] soft_irq_ext
);

   // owner code 0 means free, so port p is recorded as p+1
   localparam int OW = $clog2(N_CPU + 1);
   localparam int IW = (N_CPU > 1) ? $clog2(N_CPU) : 1;

   typedef struct packed {
      logic [mbs_pkg::DATA_W-1:0] mbox;
      logic lock_irq_polarity;
      logic [1:0] route;
      logic [1:0] force_lvl;
      logic [1:0] status;
      logic [1:0] mask;
      logic [N_CPU-1:0] wait_req;
      logic [mbs_pkg::DATA_W-1:0] rdata;
      logic [IW-1:0] last;
      logic irq;
      logic [1:0] cpu_line;
      logic [1:0] ext_line;
   } mbs_top_st_t;

   mbs_top_st_t s_r;
   mbs_top_st_t s_nxt;

   logic [N_CPU-1:0] pend;
   logic gnt_ok;
   logic [IW-1:0] gnt;
   mbs_pkg::mbs_av_req_t req;
   logic [1:0] take_go;
   logic [1:0] free_go;
   logic [OW-1:0] who;
   logic [1:0] busy;
   logic [OW-1:0] holder [2];
   logic [1:0] busy_nxt;
   logic [1:0] chg;
   logic [1:0] force_ev;
   logic [1:0] line;
   logic [1:0] stat_clr;

   // one lock engine per semaphore
   mbs_lock #(
      .OW(OW)
   ) u_lock_zero ( // R5
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .take_req(take_go[0]),
      .free_req(free_go[0]),
      .who(who),
      .busy(busy[0]),
      .holder(holder[0])
   );

   mbs_lock #(
      .OW(OW)
   ) u_lock_one ( // R5
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .take_req(take_go[1]),
      .free_req(free_go[1]),
      .who(who),
      .busy(busy[1]),
      .holder(holder[1])
   );

   // a port is pending while it requests and is not in its answer cycle
   always_comb begin
      for (int p = 0; p < N_CPU; p++) begin
         pend[p] = (av_req[p].read || av_req[p].write) && s_r.wait_req[p];
      end
   end

   // round robin over the ports; one access per cycle keeps takes atomic
   always_comb begin
      int idx;
      idx = 0;
      gnt_ok = 1'b0;
      gnt = '0;
      for (int i = 0; i < N_CPU; i++) begin
         idx = (int'(s_r.last) + 1 + i) % N_CPU;
         if (!gnt_ok && pend[idx]) begin
            gnt_ok = 1'b1; // R17
            gnt = IW'(idx);
         end
      end
   end

   assign req = av_req[gnt];
   assign who = OW'(gnt) + OW'(1);

   // register access, lock strobes and interrupt bookkeeping
   always_comb begin
      s_nxt = s_r;
      s_nxt.wait_req = '1;
      take_go = 2'h0;
      free_go = 2'h0;
      force_ev = 2'h0;
      stat_clr = 2'h0;
      if (gnt_ok) begin
         s_nxt.wait_req[gnt] = 1'b0;
         s_nxt.last = gnt;
         s_nxt.rdata = '0; // unmapped reads answer zero
         if (req.write) begin
            unique case (req.address)
               mbs_pkg::OFS_MBOX_VALUE: begin
                  s_nxt.mbox = req.writedata; // R1 R2
               end
               mbs_pkg::OFS_MBOX_SET_MASK: begin
                  s_nxt.mbox = s_r.mbox | req.writedata; // R4
               end
               mbs_pkg::OFS_MBOX_BIT_CLEAR_MASK: begin
                  s_nxt.mbox = s_r.mbox & ~req.writedata; // R3
               end
               mbs_pkg::OFS_LOCK_IRQ_CONFIG: begin
                  s_nxt.lock_irq_polarity =
                     req.writedata[mbs_pkg::CFG_POLARITY_BIT]; // R13
                  s_nxt.route =
                     req.writedata[mbs_pkg::CFG_ROUTE_LSB +: 2]; // R16
               end
               mbs_pkg::OFS_LOCK_ZERO_TAKE: begin
                  free_go[0] = req.writedata[mbs_pkg::TAKE_BIT]; // R9 R10
               end
               mbs_pkg::OFS_LOCK_ONE_TAKE: begin
                  free_go[1] = req.writedata[mbs_pkg::TAKE_BIT]; // R9 R10
               end
               mbs_pkg::OFS_IRQ_MANUAL_TRIGGER: begin
                  // a newly raised force bit also counts as an event
                  force_ev = req.writedata[1:0] & ~s_r.force_lvl;
                  s_nxt.force_lvl = req.writedata[1:0]; // R15
               end
               mbs_pkg::OFS_IRQ_MASK: begin
                  s_nxt.mask = req.writedata[1:0];
               end
               default: begin
                  // read-only and unmapped words ignore writes
               end
            endcase
         end else begin
            unique case (req.address)
               mbs_pkg::OFS_MBOX_VALUE: begin
                  s_nxt.rdata = s_r.mbox; // R2
               end
               mbs_pkg::OFS_LOCK_IRQ_CONFIG: begin
                  s_nxt.rdata[mbs_pkg::CFG_POLARITY_BIT] = s_r.lock_irq_polarity;
                  s_nxt.rdata[mbs_pkg::CFG_ROUTE_LSB +: 2] = s_r.route;
               end
               mbs_pkg::OFS_LOCK_ZERO_TAKE: begin
                  // only a free lock answers 1; held ones answer 0
                  take_go[0] = 1'b1;
                  s_nxt.rdata[mbs_pkg::TAKE_BIT] = !busy[0]; // R6 R7 R8
               end
               mbs_pkg::OFS_LOCK_ONE_TAKE: begin
                  take_go[1] = 1'b1;
                  s_nxt.rdata[mbs_pkg::TAKE_BIT] = !busy[1]; // R6 R7 R8
               end
               mbs_pkg::OFS_LOCK_ZERO_HOLDER: begin
                  s_nxt.rdata[OW-1:0] = holder[0]; // R11
                  s_nxt.rdata[mbs_pkg::HOLDER_BUSY_BIT] = busy[0];
               end
               mbs_pkg::OFS_LOCK_ONE_HOLDER: begin
                  s_nxt.rdata[OW-1:0] = holder[1]; // R11
                  s_nxt.rdata[mbs_pkg::HOLDER_BUSY_BIT] = busy[1];
               end
               mbs_pkg::OFS_IRQ_MANUAL_TRIGGER: begin
                  s_nxt.rdata[1:0] = s_r.force_lvl;
               end
               mbs_pkg::OFS_IRQ_STATUS: begin
                  s_nxt.rdata[1:0] = s_r.status;
                  stat_clr = 2'h3;
               end
               mbs_pkg::OFS_IRQ_MASK: begin
                  s_nxt.rdata[1:0] = s_r.mask;
               end
               default: begin
                  // set and clear masks are write-only, read as zero
               end
            endcase
         end
      end

      // lock state as it will stand after this cycle
      for (int k = 0; k < 2; k++) begin
         busy_nxt[k] = free_go[k] ? 1'b0 : (busy[k] || take_go[k]);
         chg[k] = busy_nxt[k] != busy[k]; // R12
      end

      // lock zero drives line zero, lock one line one
      line = (busy_nxt ^ {2{s_nxt.lock_irq_polarity}}) | s_nxt.force_lvl; // R14 R13 R15

      // new events win over the read that clears the status
      s_nxt.status = (s_r.status & ~stat_clr) | chg | force_ev; // R12
      s_nxt.irq = |(s_nxt.status & s_nxt.mask);

      // route bit 0 keeps a line on the cpu, 1 sends it out
      s_nxt.cpu_line = line & ~s_nxt.route; // R16
      s_nxt.ext_line = line & s_nxt.route; // R16
   end

   // all control state, including mailbox, resets to constants
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_r.mbox <= mbs_pkg::MBOX_RST; // R18
         s_r.lock_irq_polarity <= mbs_pkg::LOCK_POLARITY_RST;
         s_r.route <= mbs_pkg::ROUTE_RST;
         s_r.force_lvl <= mbs_pkg::FORCE_RST;
         s_r.status <= mbs_pkg::STATUS_RST;
         s_r.mask <= mbs_pkg::MASK_RST;
         s_r.wait_req <= '1;
         s_r.rdata <= '0;
         s_r.last <= IW'(N_CPU - 1);
         s_r.irq <= 1'b0;
         s_r.cpu_line <= 2'h0;
         s_r.ext_line <= 2'h0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // every port sees the shared read word; only the acked one takes it
   always_comb begin
      for (int p = 0; p < N_CPU; p++) begin
         av_rsp[p].waitrequest = s_r.wait_req[p];
         av_rsp[p].readdata = s_r.rdata;
      end
   end

   assign irq = s_r.irq;
   assign soft_irq_cpu = s_r.cpu_line;
   assign soft_irq_ext = s_r.ext_line;

endmodule

`default_nettype wire

/* tb/mbs_top_monitor.sv */
`default_nettype none
module mbs_top_monitor #(
   parameter int N_CPU = 2
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire mbs_pkg::mbs_av_req_t [N_CPU-1:0] av_req,
   input wire mbs_pkg::mbs_av_rsp_t [N_CPU-1:0] av_rsp,
   input wire logic irq,
   input wire logic [1:0] soft_irq_cpu,
   input wire logic [1:0] soft_irq_ext
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] tk;
   logic [1:0] rl;
   logic [1:0] hd;
   logic held_r;
   // answered take reads, releases and holder reads of lock zero per port
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         tk[p] = !av_rsp[p].waitrequest && av_req[p].read
            && av_req[p].address == mbs_pkg::OFS_LOCK_ZERO_TAKE;
         rl[p] = !av_rsp[p].waitrequest && av_req[p].write && av_req[p].writedata[0]
            && av_req[p].address == mbs_pkg::OFS_LOCK_ZERO_TAKE;
         hd[p] = !av_rsp[p].waitrequest && av_req[p].read
            && av_req[p].address == mbs_pkg::OFS_LOCK_ZERO_HOLDER;
      end
   end
   // shadow of lock zero; answers are serialised so one event per cycle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) held_r <= 1'b0;
      else if (|rl) held_r <= 1'b0;
      else if (|tk) held_r <= 1'b1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   chk_ack_pulse: assert property (!av_rsp[0].waitrequest |=> av_rsp[0].waitrequest)
      else $error("answer held longer than one cycle");
   chk_ack_one: assert property (!av_rsp[1].waitrequest |=> av_rsp[1].waitrequest)
      else $error("answer held longer than one cycle");
   chk_idle_wait: assert property (
      !(av_req[1].read || av_req[1].write) |=> av_rsp[1].waitrequest)
      else $error("answer without a request");
   chk_idle_zero: assert property (
      !(av_req[0].read || av_req[0].write) |=> av_rsp[0].waitrequest)
      else $error("answer without a request");
   chk_free_one: assert property (tk[1] && !held_r |-> av_rsp[1].readdata[0])
      else $error("free lock not granted");
   chk_take_free: assert property (tk[0] && !held_r |-> av_rsp[0].readdata[0])
      else $error("free lock not granted");
   chk_take_held: assert property (tk[1] && held_r |-> !av_rsp[1].readdata[0])
      else $error("held lock granted again");
   chk_holder_busy: assert property (hd[0] |-> av_rsp[0].readdata[8] == held_r)
      else $error("holder busy bit wrong");
   // a take answered 1 on either port leaves every later take on 0 until a release
   chk_one_winner: assert property (
      held_r && (tk[0] || tk[1])
      |-> !(tk[0] && av_rsp[0].readdata[0]) && !(tk[1] && av_rsp[1].readdata[0]))
      else $error("two winners of one lock");
   chk_route_once: assert property (!(|(soft_irq_cpu & soft_irq_ext)))
      else $error("soft line routed to both sides");
   chk_mask_rd_zero: assert property (
      !av_rsp[0].waitrequest && av_req[0].read
      && av_req[0].address == mbs_pkg::OFS_MBOX_BIT_CLEAR_MASK |-> av_rsp[0].readdata == '0)
      else $error("clear mask read not zero");
endmodule
bind mbs_top mbs_top_monitor #(.N_CPU(N_CPU)) mon_u (.clk_sys(clk_sys), .rst_b(rst_b),
   .av_req(av_req), .av_rsp(av_rsp), .irq(irq), .soft_irq_cpu(soft_irq_cpu),
   .soft_irq_ext(soft_irq_ext));
`default_nettype wire

/* tb/mbs_cpu_model.sv */
`default_nettype none
module mbs_cpu_model (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic go,
   input wire mbs_pkg::mbs_av_req_t cmd,
   input wire mbs_pkg::mbs_av_rsp_t rsp,
   output mbs_pkg::mbs_av_req_t req,
   output logic done,
   output logic [31:0] rdat
);
   timeunit 1ns;
   timeprecision 1ps;
   // holds the request until waitrequest is seen low, then scrambles idle lines
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         req <= '0;
         done <= 1'b0;
         rdat <= '0;
      end else begin
         done <= 1'b0;
         if (go && !(req.read || req.write)) req <= cmd;
         else if ((req.read || req.write) && !rsp.waitrequest) begin
            req <= '{1'b0, 1'b0, ~req.address, ~req.writedata};
            rdat <= rsp.readdata;
            done <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* tb/mbs_top_tb_top.sv */
`default_nettype none
module mbs_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] go = 2'h0;
   wire logic [1:0] done;
   mbs_pkg::mbs_av_req_t cmd [2] = '{default: '0};
   wire mbs_pkg::mbs_av_req_t [1:0] av_req;
   mbs_pkg::mbs_av_rsp_t [1:0] av_rsp;
   logic [31:0] rdat [2];
   logic irq;
   logic [1:0] soft_irq_cpu;
   logic [1:0] soft_irq_ext;
   logic [31:0] q0;
   logic [31:0] q1;
   int mismatches = 0;
   int compares = 0;
   mbs_top dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .av_req(av_req), .av_rsp(av_rsp),
      .irq(irq), .soft_irq_cpu(soft_irq_cpu), .soft_irq_ext(soft_irq_ext));
   // one cpu model per register port
   for (genvar p = 0; p < 2; p++) begin : g_cpu
      mbs_cpu_model cpu_u (.clk_sys(clk_sys), .rst_b(rst_b), .go(go[p]), .cmd(cmd[p]),
         .rsp(av_rsp[p]), .req(av_req[p]), .done(done[p]), .rdat(rdat[p]));
   end
   initial forever #2.5 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one access; a hung answer counts as a mismatch
   task automatic acc(input int p, input logic r, input logic [5:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge clk_sys);
      go[p] <= 1'b1;
      cmd[p] <= '{r, !r, a, d};
      @(posedge clk_sys);
      go[p] <= 1'b0;
      for (int i = 0; i < 30 && done[p] !== 1'b1; i++) @(posedge clk_sys);
      if (done[p] !== 1'b1) chk(32'hDEAD_DEAD, 32'h0000_0000);
      q = rdat[p];
   endtask
   task automatic wr(input int p, input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      acc(p, 1'b0, a, d, q);
   endtask
   task automatic rd(input int p, input logic [5:0] a, input logic [31:0] exp);
      logic [31:0] q;
      acc(p, 1'b1, a, 32'h0000_0000, q);
      chk(q, exp);
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog far beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      conclude();
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(0, 6'h00, 32'h0000_0000);
      rd(1, 6'h18, 32'h0000_0000);
      wr(0, 6'h00, 32'hA5A5_0F0F);
      rd(1, 6'h00, 32'hA5A5_0F0F);
      wr(1, 6'h04, 32'h0000_F0F0);
      rd(0, 6'h00, 32'hA5A5_FFFF);
      wr(0, 6'h08, 32'hFF00_000F);
      rd(1, 6'h00, 32'h00A5_FFF0);
      rd(0, 6'h08, 32'h0000_0000);
      rd(0, 6'h3C, 32'h0000_0000);
      rd(0, 6'h10, 32'h0000_0001);
      rd(1, 6'h18, 32'h0000_0101);
      rd(1, 6'h10, 32'h0000_0000);
      rd(0, 6'h10, 32'h0000_0000);
      rd(1, 6'h14, 32'h0000_0001);
      rd(0, 6'h1C, 32'h0000_0102);
      chk({30'h0, soft_irq_cpu}, 32'h0000_0003);
      wr(0, 6'h14, 32'h0000_0000);
      rd(0, 6'h1C, 32'h0000_0102);
      wr(1, 6'h10, 32'h0000_0001);
      rd(0, 6'h18, 32'h0000_0000);
      chk({30'h0, soft_irq_cpu}, 32'h0000_0002);
      wr(0, 6'h0C, 32'h0000_0003);
      chk({30'h0, soft_irq_ext}, 32'h0000_0001);
      chk({30'h0, soft_irq_cpu}, 32'h0000_0000);
      wr(0, 6'h0C, 32'h0000_0001);
      wr(1, 6'h14, 32'h0000_0001);
      chk({30'h0, soft_irq_cpu}, 32'h0000_0003);
      wr(0, 6'h0C, 32'h0000_0000);
      // both ports race for the free lock zero
      fork
         acc(0, 1'b1, 6'h10, 32'h0, q0);
         acc(1, 1'b1, 6'h10, 32'h0, q1);
      join
      chk({31'h0, q0[0]} + {31'h0, q1[0]}, 32'h0000_0001);
      wr(1, 6'h10, 32'h0000_0001);
      wr(0, 6'h28, 32'h0000_0003);
      rd(0, 6'h24, 32'h0000_0003);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(1, 6'h20, 32'h0000_0001);
      chk({30'h0, soft_irq_cpu}, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0001);
      rd(0, 6'h24, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0000);
      rd(1, 6'h20, 32'h0000_0001);
      rd(1, 6'h28, 32'h0000_0003);
      // line one sent out while line zero stays on the cpu
      wr(0, 6'h0C, 32'h0000_0005);
      chk({30'h0, soft_irq_ext}, 32'h0000_0002);
      chk({30'h0, soft_irq_cpu}, 32'h0000_0001);
      rd(0, 6'h0C, 32'h0000_0005);
      rd(0, 6'h14, 32'h0000_0001);
      // second reset in mid-run: held lock, mailbox and lines back to idle
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      chk({29'h0, irq, soft_irq_ext}, 32'h0000_0000);
      chk({30'h0, soft_irq_cpu}, 32'h0000_0000);
      rd(1, 6'h1C, 32'h0000_0000);
      rd(1, 6'h00, 32'h0000_0000);
      rd(1, 6'h0C, 32'h0000_0000);
      rd(1, 6'h14, 32'h0000_0001);
      conclude();
   end
endmodule
`default_nettype wire
